// [logic/pesc_pkg.sv]
// Constants, field layout and carrier types of the extended status and
// configuration register pair.
// Assumes a single 100 MHz clock domain and a 32-bit Avalon-MM slave.
package pesc_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_CTRL_TWO = 6'h1a;
    localparam logic [5:0] IDX_EXT_STATUS = 6'h1b;
    localparam int ADDR_W = 8;
    localparam int IDX_LSB = 2;

    // Field positions of the control-two register.
    localparam int AMP_LSB = 0;
    localparam int AMP_MSB = 2;

    // Field positions of the extended status register.
    localparam int ST_AUTOSEL_OFF = 15;
    localparam int ST_RESERVED = 14;
    localparam int ST_RESOLUTION = 13;
    localparam int ST_BYP_EN = 12;
    localparam int ST_BYP_STAT = 11;
    localparam int ST_IRQ_POL = 10;
    localparam int ST_AMRS_OFF = 9;
    localparam int ST_HYST_LSB = 5;
    localparam int ST_HYST_MSB = 8;
    localparam int ST_DTE = 4;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_MODE_MSB = 3;

    // Reset values.
    localparam logic [2:0] AMP_RST = 3'h2;
    localparam logic [3:0] HYST_RST = 4'h4;
    localparam logic AMRS_RST = 1'b0;
    localparam logic [15:0] REG_ZERO = 16'h0000;

    // Output swing in millivolts: base at code zero plus one step per code.
    localparam logic [15:0] AMP100_BASE_MV = 16'h01f4;
    localparam logic [15:0] AMP150_BASE_MV = 16'h026c;
    localparam logic [15:0] AMP_STEP_MV = 16'h0064;

    // Hardware configuration mode codes.
    localparam logic [3:0] MODE_SGMII_CLK = 4'h0;
    localparam logic [3:0] MODE_SGMII_NOCLK = 4'h4;
    localparam logic [3:0] MODE_X_AN = 4'h8;
    localparam logic [3:0] MODE_X_NOAN = 4'hc;
    localparam logic [3:0] MODE_RTBI_CU = 4'h9;
    localparam logic [3:0] MODE_TBI_CU = 4'hd;
    localparam logic [3:0] MODE_GMII_FIBER = 4'h7;
    localparam logic [3:0] MODE_GMII_CU = 4'hf;
    localparam logic [3:0] MODE_RGMII_CU = 4'hb;
    localparam logic [3:0] MODE_RGMII_FIBER = 4'h3;

    // Timing.
    localparam longint CLK_HZ = 64'h0000_0000_05f5_e100;
    localparam longint DTE_STEP_S = 64'h0000_0000_0000_0005;
    localparam int unsigned DTE_STEP_CYCLES = 32'(DTE_STEP_S * CLK_HZ);
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    typedef enum logic [2:0] {
        PESC_IF_SGMII,
        PESC_IF_1000X,
        PESC_IF_RTBI,
        PESC_IF_TBI,
        PESC_IF_GMII,
        PESC_IF_RGMII,
        PESC_IF_NONE
    } pesc_mac_if_t;

    typedef struct packed {
        pesc_mac_if_t mac_if;
        logic fiber;
        logic serial_an;
        logic serial_clk;
        logic reserved;
    } pesc_path_t;

    typedef struct packed {
        logic autosel_off;
        logic bypass_en;
        logic irq_pol_low;
        logic [3:0] mode;
    } pesc_disr_t;

endpackage : pesc_pkg

// [logic/pesc_regs.sv]
// Extended status and configuration register pair with its control logic.
// Assumes straps and link pins are asynchronous, while sw_reset and
// irq_event come from logic on sys_clk.
//
// What this block does
// - 3-bit amplitude, reset 010, gives 0.50V to 1.20V into 100 ohm.
// - Same codes give 0.62V to 1.32V into 150 ohm, 0.10V steps.
// - Status bit 15 set disables fiber/copper media auto-selection.
// - Auto-selection disable bit loads its strap level on hardware reset.
// - Disruptive fields written take effect only after a software reset.
// - Read-only bit 13 shows resolved medium, one fiber, zero copper.
// - Bypass enable defaults one for modes 0111, 0011, 1000, else strap.
// - Bit 11 set when serial link came up by bypass timer expiry.
// - SGMII bypass link-up restarts copper negotiation, advertising gigabit.
// - While bypass status is one, the fiber negotiation-done bit reads zero.
// - Bit 9, reset zero, disables automatic medium register selection.
// - Hysteresis field, reset 0x4, delays dropped DTE report code times 5s.
// - Read-only bit 4 shows link partner needs DTE power.
// - Mode field bits 3 to 0 load the mode straps on hardware reset.
// - Modes 0000, 0100, 1000, 1100 select SGMII or 1000BASE-X to copper.
// - Mode 1001 selects reduced ten-bit, 1101 full ten-bit, to copper.
// - Mode 0111 GMII fiber, 1111 GMII copper, 1011 RGMII copper.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pesc_regs #(
    parameter int unsigned DTE_STEP_CYCLES = pesc_pkg::DTE_STEP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sw_reset,
    input wire logic irq_event,
    input wire logic media_autoselect_off_strap,
    input wire logic irq_polarity_strap,
    input wire logic bypass_en_strap,
    input wire logic [3:0] hw_config_mode,
    input wire logic link_up,
    input wire logic medium_fiber,
    input wire logic serdes_link_up,
    input wire logic serdes_bypass_used,
    input wire logic fiber_an_done,
    input wire logic dte_power_need,
    output logic [2:0] amp_code,
    output logic [15:0] amp_100_mv,
    output logic [15:0] amp_150_mv,
    output logic media_autoselect_off,
    output logic auto_medium_reg_sel_off,
    output logic irq_out,
    output pesc_pkg::pesc_path_t path_cfg,
    output logic copper_an_restart,
    output logic copper_adv_gig_only,
    output logic fiber_an_done_report,
    output logic dte_power_status
);

    // Swing in millivolts for a given base and amplitude code.
    function automatic logic [15:0] amp_mv(input logic [15:0] base,
                                           input logic [2:0] code);
        amp_mv = 16'(base + pesc_pkg::AMP_STEP_MV * 16'(code));
    endfunction : amp_mv

    // Media path and MAC interface picked by a configuration mode code.
    function automatic pesc_pkg::pesc_path_t decode_mode(
        input logic [3:0] mode);
        pesc_pkg::pesc_path_t p;
        p = '{mac_if: pesc_pkg::PESC_IF_NONE, fiber: 1'b0, serial_an: 1'b0,
              serial_clk: 1'b0, reserved: 1'b0};
        unique case (mode)
            pesc_pkg::MODE_SGMII_CLK: begin
                p.mac_if = pesc_pkg::PESC_IF_SGMII;
                p.serial_an = 1'b1;
                p.serial_clk = 1'b1;
            end
            pesc_pkg::MODE_SGMII_NOCLK: begin
                p.mac_if = pesc_pkg::PESC_IF_SGMII;
                p.serial_an = 1'b1;
            end
            pesc_pkg::MODE_X_AN: begin
                p.mac_if = pesc_pkg::PESC_IF_1000X;
                p.serial_an = 1'b1;
            end
            pesc_pkg::MODE_X_NOAN: begin
                p.mac_if = pesc_pkg::PESC_IF_1000X;
            end
            pesc_pkg::MODE_RTBI_CU: begin
                p.mac_if = pesc_pkg::PESC_IF_RTBI;
            end
            pesc_pkg::MODE_TBI_CU: begin
                p.mac_if = pesc_pkg::PESC_IF_TBI;
            end
            pesc_pkg::MODE_GMII_FIBER: begin
                p.mac_if = pesc_pkg::PESC_IF_GMII;
                p.fiber = 1'b1;
            end
            pesc_pkg::MODE_GMII_CU: begin
                p.mac_if = pesc_pkg::PESC_IF_GMII;
            end
            pesc_pkg::MODE_RGMII_CU: begin
                p.mac_if = pesc_pkg::PESC_IF_RGMII;
            end
            pesc_pkg::MODE_RGMII_FIBER: begin
                p.mac_if = pesc_pkg::PESC_IF_RGMII;
                p.fiber = 1'b1;
            end
            default: begin
                p.reserved = 1'b1;
            end
        endcase
        decode_mode = p;
    endfunction : decode_mode

    // True for modes whose bypass enable defaults to one.
    function automatic logic bypass_default(input logic [3:0] mode,
                                            input logic strap);
        bypass_default = (mode == pesc_pkg::MODE_GMII_FIBER) ||
                         (mode == pesc_pkg::MODE_RGMII_FIBER) ||
                         (mode == pesc_pkg::MODE_X_AN) || strap;
    endfunction : bypass_default

    // Two-flop synchroniser for every pin input and strap.
    logic [12:0] sync1_reg;
    logic [12:0] sync2_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 13'h0000;
            sync2_reg <= 13'h0000;
        end else begin
            sync1_reg <= {media_autoselect_off_strap, irq_polarity_strap,
                          bypass_en_strap, hw_config_mode, link_up,
                          medium_fiber, serdes_link_up, serdes_bypass_used,
                          fiber_an_done, dte_power_need};
            sync2_reg <= sync1_reg;
        end
    end

    logic s_autosel;
    logic s_irqpol;
    logic s_byp;
    logic [3:0] s_mode;
    logic s_link;
    logic s_medium;
    logic s_serdes;
    logic s_bypused;
    logic s_andone;
    logic s_dte;
    assign {s_autosel, s_irqpol, s_byp, s_mode, s_link, s_medium, s_serdes,
            s_bypused, s_andone, s_dte} = sync2_reg;

    // Strap capture waits for the synchroniser to fill after reset.
    logic [1:0] strap_cnt_reg;
    logic [1:0] strap_cnt_next;
    logic loaded_reg;
    logic loaded_next;
    logic strap_load;
    always_comb begin
        strap_cnt_next = strap_cnt_reg;
        loaded_next = loaded_reg;
        strap_load = 1'b0;
        if (!loaded_reg) begin
            if (strap_cnt_reg == pesc_pkg::STRAP_SETTLE) begin
                strap_load = 1'b1;
                loaded_next = 1'b1;
            end else begin
                strap_cnt_next = 2'(strap_cnt_reg + 2'h1);
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_reg <= 2'h0;
            loaded_reg <= 1'b0;
        end else begin
            strap_cnt_reg <= strap_cnt_next;
            loaded_reg <= loaded_next;
        end
    end

    // Avalon-MM slave: one wait cycle, then the answer.
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic req;
    logic wr_take;
    logic [5:0] idx;
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_reg;
    assign wr_take = avs_write & ack_reg;
    assign idx = avs_address[pesc_pkg::ADDR_W-1:pesc_pkg::IDX_LSB];
    assign avs_readdata = rdata_reg;

    // Configuration state.
    logic [2:0] amp_reg;
    logic [2:0] amp_next;
    logic amrs_reg;
    logic amrs_next;
    logic [3:0] hyst_reg;
    logic [3:0] hyst_next;
    pesc_pkg::pesc_disr_t shadow_reg;
    pesc_pkg::pesc_disr_t shadow_next;
    pesc_pkg::pesc_disr_t active_reg;
    pesc_pkg::pesc_disr_t active_next;

    // Status state.
    logic res_reg;
    logic res_next;
    logic byp_stat_reg;
    logic byp_stat_next;
    logic serdes_prev_reg;
    logic dte_reg;
    logic dte_next;
    logic [31:0] pre_reg;
    logic [31:0] pre_next;
    logic [3:0] step_reg;
    logic [3:0] step_next;

    logic [15:0] ctrl_two_view;
    logic [15:0] status_view;
    always_comb begin
        ctrl_two_view = pesc_pkg::REG_ZERO;
        ctrl_two_view[pesc_pkg::AMP_MSB:pesc_pkg::AMP_LSB] = amp_reg;
        status_view = pesc_pkg::REG_ZERO;
        status_view[pesc_pkg::ST_AUTOSEL_OFF] = shadow_reg.autosel_off;
        status_view[pesc_pkg::ST_RESOLUTION] = res_reg;
        status_view[pesc_pkg::ST_BYP_EN] = shadow_reg.bypass_en;
        status_view[pesc_pkg::ST_BYP_STAT] = byp_stat_reg;
        status_view[pesc_pkg::ST_IRQ_POL] = shadow_reg.irq_pol_low;
        status_view[pesc_pkg::ST_AMRS_OFF] = amrs_reg;
        status_view[pesc_pkg::ST_HYST_MSB:pesc_pkg::ST_HYST_LSB] = hyst_reg;
        status_view[pesc_pkg::ST_DTE] = dte_reg;
        status_view[pesc_pkg::ST_MODE_MSB:pesc_pkg::ST_MODE_LSB] =
            shadow_reg.mode;
    end

    always_comb begin
        ack_next = req & ~ack_reg & loaded_reg;
        rdata_next = rdata_reg;
        if (avs_read && !ack_reg) begin
            rdata_next = 32'h0000_0000;
            if (idx == pesc_pkg::IDX_CTRL_TWO) begin
                rdata_next[15:0] = ctrl_two_view;
            end else if (idx == pesc_pkg::IDX_EXT_STATUS) begin
                rdata_next[15:0] = status_view;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // Register writes, strap loading and software reset.
    always_comb begin
        amp_next = amp_reg;
        amrs_next = amrs_reg;
        hyst_next = hyst_reg;
        shadow_next = shadow_reg;
        active_next = active_reg;
        if (strap_load) begin
            shadow_next.autosel_off = s_autosel;
            shadow_next.irq_pol_low = s_irqpol;
            shadow_next.mode = s_mode;
            shadow_next.bypass_en = bypass_default(s_mode, s_byp);
            active_next = shadow_next;
        end else begin
            if (wr_take && idx == pesc_pkg::IDX_CTRL_TWO &&
                avs_byteenable[0]) begin
                amp_next = avs_writedata[pesc_pkg::AMP_MSB:pesc_pkg::AMP_LSB];
            end
            if (wr_take && idx == pesc_pkg::IDX_EXT_STATUS) begin
                // Bit 14 is reserved: the write is dropped, it reads zero.
                if (avs_byteenable[1]) begin
                    shadow_next.autosel_off =
                        avs_writedata[pesc_pkg::ST_AUTOSEL_OFF];
                    shadow_next.bypass_en = avs_writedata[pesc_pkg::ST_BYP_EN];
                    shadow_next.irq_pol_low =
                        avs_writedata[pesc_pkg::ST_IRQ_POL];
                    amrs_next = avs_writedata[pesc_pkg::ST_AMRS_OFF];
                    hyst_next[3] = avs_writedata[pesc_pkg::ST_HYST_MSB];
                end
                if (avs_byteenable[0]) begin
                    hyst_next[2:0] =
                        avs_writedata[pesc_pkg::ST_HYST_MSB-1:
                                      pesc_pkg::ST_HYST_LSB];
                    shadow_next.mode =
                        avs_writedata[pesc_pkg::ST_MODE_MSB:
                                      pesc_pkg::ST_MODE_LSB];
                end
            end
            if (sw_reset) begin
                active_next = shadow_reg;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            amp_reg <= pesc_pkg::AMP_RST;
            amrs_reg <= pesc_pkg::AMRS_RST;
            hyst_reg <= pesc_pkg::HYST_RST;
            shadow_reg <= '0;
            active_reg <= '0;
        end else begin
            amp_reg <= amp_next;
            amrs_reg <= amrs_next;
            hyst_reg <= hyst_next;
            shadow_reg <= shadow_next;
            active_reg <= active_next;
        end
    end

    // Medium resolution, bypass status and DTE power hysteresis.
    logic serdes_rise;
    logic sgmii_mode;
    logic bypass_up;
    logic step_tick;
    assign serdes_rise = s_serdes & ~serdes_prev_reg;
    assign sgmii_mode = (active_reg.mode == pesc_pkg::MODE_SGMII_CLK) ||
                        (active_reg.mode == pesc_pkg::MODE_SGMII_NOCLK);
    assign bypass_up = serdes_rise & s_bypused & active_reg.bypass_en;
    assign step_tick = (pre_reg == DTE_STEP_CYCLES - 32'h0000_0001);

    always_comb begin
        res_next = s_link ? s_medium : res_reg;
        byp_stat_next = byp_stat_reg;
        if (serdes_rise) begin
            byp_stat_next = bypass_up;
        end
        dte_next = dte_reg;
        pre_next = pre_reg;
        step_next = step_reg;
        if (s_dte) begin
            dte_next = 1'b1;
            pre_next = 32'h0000_0000;
            step_next = 4'h0;
        end else if (dte_reg) begin
            if (step_reg == hyst_reg) begin
                dte_next = 1'b0;
            end else if (step_tick) begin
                pre_next = 32'h0000_0000;
                step_next = 4'(step_reg + 4'h1);
            end else begin
                pre_next = 32'(pre_reg + 32'h0000_0001);
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_reg <= 1'b0;
            byp_stat_reg <= 1'b0;
            serdes_prev_reg <= 1'b0;
            dte_reg <= 1'b0;
            pre_reg <= 32'h0000_0000;
            step_reg <= 4'h0;
        end else begin
            res_reg <= res_next;
            byp_stat_reg <= byp_stat_next;
            serdes_prev_reg <= s_serdes;
            dte_reg <= dte_next;
            pre_reg <= pre_next;
            step_reg <= step_next;
        end
    end

    // Registered control outputs driven from the active settings.
    pesc_pkg::pesc_path_t path_reg;
    pesc_pkg::pesc_path_t path_next;
    logic [15:0] mv100_reg;
    logic [15:0] mv100_next;
    logic [15:0] mv150_reg;
    logic [15:0] mv150_next;
    logic irq_reg;
    logic irq_next;
    logic restart_reg;
    logic restart_next;
    logic gig_reg;
    logic gig_next;
    logic andone_reg;
    logic andone_next;
    always_comb begin
        path_next = decode_mode(active_reg.mode);
        mv100_next = amp_mv(pesc_pkg::AMP100_BASE_MV, amp_reg);
        mv150_next = amp_mv(pesc_pkg::AMP150_BASE_MV, amp_reg);
        irq_next = irq_event ^ active_reg.irq_pol_low;
        restart_next = bypass_up & sgmii_mode;
        gig_next = byp_stat_next & sgmii_mode;
        andone_next = s_andone & ~byp_stat_next;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            path_reg <= '{mac_if: pesc_pkg::PESC_IF_NONE, fiber: 1'b0,
                          serial_an: 1'b0, serial_clk: 1'b0, reserved: 1'b0};
            mv100_reg <= 16'h0000;
            mv150_reg <= 16'h0000;
            irq_reg <= 1'b0;
            restart_reg <= 1'b0;
            gig_reg <= 1'b0;
            andone_reg <= 1'b0;
        end else begin
            path_reg <= path_next;
            mv100_reg <= mv100_next;
            mv150_reg <= mv150_next;
            irq_reg <= irq_next;
            restart_reg <= restart_next;
            gig_reg <= gig_next;
            andone_reg <= andone_next;
        end
    end

    assign amp_code = amp_reg;
    assign amp_100_mv = mv100_reg;
    assign amp_150_mv = mv150_reg;
    assign media_autoselect_off = active_reg.autosel_off;
    assign auto_medium_reg_sel_off = amrs_reg;
    assign irq_out = irq_reg;
    assign path_cfg = path_reg;
    assign copper_an_restart = restart_reg;
    assign copper_adv_gig_only = gig_reg;
    assign fiber_an_done_report = andone_reg;
    assign dte_power_status = dte_reg;

endmodule : pesc_regs

`default_nettype wire

// [tb/pesc_regs_asserts.sv]
// Port-level checker of the register pair.
// Assumes it is bound to pesc_regs on a single sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module pesc_regs_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic sw_reset,
    input wire logic dte_power_need,
    input wire logic [2:0] amp_code,
    input wire logic [15:0] amp_100_mv,
    input wire logic [15:0] amp_150_mv,
    input wire logic media_autoselect_off,
    input wire pesc_pkg::pesc_path_t path_cfg,
    input wire logic copper_an_restart,
    input wire logic dte_power_status
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence amp_wr;
        avs_write && !avs_waitrequest && avs_address == 8'h68
            && avs_byteenable[0];
    endsequence
    sequence dte_held;
        dte_power_need [*5];
    endsequence
    chk_amp_100_mv: assert property ($past(rst_n) |->
        amp_100_mv == 16'h01f4 + 16'h0064 * 16'($past(amp_code)))
        else $error("amp_100_mv wrong");
    chk_amp_150_mv: assert property ($past(rst_n) |->
        amp_150_mv == 16'h026c + 16'h0064 * 16'($past(amp_code)))
        else $error("amp_150_mv wrong");
    chk_amp_write: assert property (amp_wr |=>
        amp_code == $past(avs_writedata[2:0]))
        else $error("amp write lost");
    chk_dte_rise: assert property (dte_held |-> dte_power_status)
        else $error("dte status missing");
    chk_restart_pulse: assert property (copper_an_restart |=>
        !copper_an_restart) else $error("restart too long");
    chk_restart_mode: assert property (copper_an_restart |->
        path_cfg.mac_if == pesc_pkg::PESC_IF_SGMII)
        else $error("restart outside SGMII");
    chk_sw_gate: assert property ($past(rst_n, 8) &&
        ($changed(path_cfg) || $changed(media_autoselect_off)) |->
        $past(sw_reset) || $past(sw_reset, 2) || $past(sw_reset, 3))
        else $error("change without sw_reset");
    chk_idle_ready: assert property (!avs_read && !avs_write |->
        !avs_waitrequest) else $error("busy while idle");
    chk_read_upper: assert property (avs_read && !avs_waitrequest |->
        avs_readdata[31:16] == 16'h0000) else $error("upper read bits set");
    chk_bus_answer: assert property ((avs_read || avs_write) &&
        avs_waitrequest |-> ##[1:8] !avs_waitrequest)
        else $error("no bus answer");
endmodule : pesc_regs_asserts

bind pesc_regs pesc_regs_asserts i_chk (
    .sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .sw_reset,
    .dte_power_need, .amp_code, .amp_100_mv, .amp_150_mv,
    .media_autoselect_off, .path_cfg, .copper_an_restart, .dte_power_status
);
`default_nettype wire

// [tb/pesc_regs_test.sv]
// Self-checking bench of the register pair over Avalon-MM.
// Assumes the package and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pesc_regs_test;
    logic sys_clk = 1'b0, rst_n = 1'b0, sw_reset = 1'b0, irq_event = 1'b0;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
    logic [3:0] avs_byteenable = 4'h3, hw_config_mode = 4'h7;
    logic media_autoselect_off_strap = 1'b1, irq_polarity_strap = 1'b0;
    logic bypass_en_strap = 1'b0, link_up = 1'b0, medium_fiber = 1'b0;
    logic serdes_link_up = 1'b0, serdes_bypass_used = 1'b0;
    logic fiber_an_done = 1'b0, dte_power_need = 1'b0;
    logic [2:0] amp_code;
    logic [15:0] amp_100_mv, amp_150_mv;
    logic media_autoselect_off, auto_medium_reg_sel_off, irq_out;
    logic copper_an_restart, copper_adv_gig_only, fiber_an_done_report;
    logic dte_power_status;
    pesc_pkg::pesc_path_t path_cfg;
    int n_mismatch = 0, tests_run = 0, n_restart = 0;
    logic [3:0] mode_tab [10] = '{4'h4, 4'h8, 4'hc, 4'h9, 4'hd, 4'h7, 4'hf,
        4'hb, 4'h3, 4'h0};
    pesc_pkg::pesc_mac_if_t if_tab [10] = '{pesc_pkg::PESC_IF_SGMII,
        pesc_pkg::PESC_IF_1000X, pesc_pkg::PESC_IF_1000X,
        pesc_pkg::PESC_IF_RTBI, pesc_pkg::PESC_IF_TBI, pesc_pkg::PESC_IF_GMII,
        pesc_pkg::PESC_IF_GMII, pesc_pkg::PESC_IF_RGMII,
        pesc_pkg::PESC_IF_RGMII, pesc_pkg::PESC_IF_SGMII};

    pesc_regs #(.DTE_STEP_CYCLES(10)) i_dut (
        .sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .sw_reset, .irq_event, .media_autoselect_off_strap,
        .irq_polarity_strap, .bypass_en_strap, .hw_config_mode, .link_up,
        .medium_fiber, .serdes_link_up, .serdes_bypass_used, .fiber_an_done,
        .dte_power_need, .amp_code, .amp_100_mv, .amp_150_mv,
        .media_autoselect_off, .auto_medium_reg_sel_off, .irq_out, .path_cfg,
        .copper_an_restart, .copper_adv_gig_only, .fiber_an_done_report,
        .dte_power_status
    );

    initial forever #5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) if (copper_an_restart === 1'b1) n_restart++;

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    // One Avalon cycle; read data lands in q at the accepting edge.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(negedge sys_clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
        if (n >= 50) chk("waitrequest", 0, 1);
        @(posedge sys_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic swr();
        @(posedge sys_clk);
        sw_reset <= 1'b1;
        @(posedge sys_clk);
        sw_reset <= 1'b0;
        cyc(4);
    endtask : swr

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        cyc(6);
        bus(0, 8'h68, 32'h0);
        chk("ctrl_two", 32'h0002, q);
        bus(0, 8'h6c, 32'h0);
        chk("ext_status", 32'h9087, q);
        chk("autosel", 1, media_autoselect_off);
        chk("mac_if", 32'(pesc_pkg::PESC_IF_GMII), path_cfg.mac_if);
        chk("fiber", 1, path_cfg.fiber);
        bus(0, 8'h00, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("reset test done");
        for (int c = 0; c < 8; c++) begin
            bus(1, 8'h68, 32'(c));
            cyc(2);
            chk("amp_100", 32'h01f4 + 32'h0064 * c, amp_100_mv);
            chk("amp_150", 32'h026c + 32'h0064 * c, amp_150_mv);
        end
        $display("amplitude test done");
        bus(0, 8'h6c, 32'h0);
        bus(1, 8'h6c, 32'h1640 | (q & 32'h4000));
        cyc(2);
        chk("amrs_off", 1, auto_medium_reg_sel_off);
        chk("autosel_held", 1, media_autoselect_off);
        bus(0, 8'h6c, 32'h0);
        chk("readback", 32'h1640, q);
        swr();
        chk("autosel_new", 0, media_autoselect_off);
        chk("irq_idle", 1, irq_out);
        @(posedge sys_clk);
        irq_event <= 1'b1;
        cyc(3);
        chk("irq_active", 0, irq_out);
        $display("software reset test done");
        for (int i = 0; i < 10; i++) begin
            bus(1, 8'h6c, 32'h1640 | 32'(mode_tab[i]));
            swr();
            chk("mac_if", if_tab[i], path_cfg.mac_if);
            chk("fiber", mode_tab[i] ==? 4'b0?11, path_cfg.fiber);
        end
        $display("mode test done");
        @(posedge sys_clk);
        serdes_bypass_used <= 1'b1;
        fiber_an_done <= 1'b1;
        serdes_link_up <= 1'b1;
        cyc(8);
        bus(0, 8'h6c, 32'h0);
        chk("bypass_stat", 1, q[11]);
        chk("an_report", 0, fiber_an_done_report);
        chk("gig_only", 1, copper_adv_gig_only);
        chk("restarts", 1, n_restart);
        @(posedge sys_clk);
        serdes_link_up <= 1'b0;
        serdes_bypass_used <= 1'b0;
        cyc(6);
        @(posedge sys_clk);
        serdes_link_up <= 1'b1;
        cyc(8);
        bus(0, 8'h6c, 32'h0);
        chk("bypass_stat", 0, q[11]);
        chk("an_report", 1, fiber_an_done_report);
        chk("gig_only", 0, copper_adv_gig_only);
        $display("bypass test done");
        @(posedge sys_clk);
        link_up <= 1'b1;
        medium_fiber <= 1'b1;
        dte_power_need <= 1'b1;
        cyc(8);
        bus(0, 8'h6c, 32'h0);
        chk("resolution", 1, q[13]);
        chk("dte_bit", 1, q[4]);
        @(posedge sys_clk);
        dte_power_need <= 1'b0;
        cyc(12);
        chk("dte_hold", 1, dte_power_status);
        cyc(20);
        chk("dte_drop", 0, dte_power_status);
        $display("medium and power test done");
        print_verdict();
    end
endmodule : pesc_regs_test
`default_nettype wire
